// ==== src/dcs_top.sv ====
// debug configuration/status register, upper half, with trace gating
// assumes: debug-port and processor requests arrive on core_clk, one cycle each
//
// What this block does
// R1 - state 0000 idle, 0001/0101 awaiting levels
// R2 - state 0010/0110 after level one/two fires
// R3 - trigger-definition write or final-level read clears state
// R4 - state read-only, debug port only
// R5 - double fault sets bit 27, read clears
// R6 - hw trigger sets bit 26, cleared variously
// R7 - halt instruction sets bit 25, cleared variously
// R8 - external break sets bit 24, cleared variously
// R9 - fixed revision in 23:20, debug port only
// R10 - bit 17 quiets status and data trace
// R11 - trace clock follows only clock-off setting
// R12 - bit 16 blocks all processor writes
// R13 - only debug port changes the lock
// R14 - processor writes only; debug port reads/writes
// R15 - selected as debug register 0x00
// R16 - debug port uses five-bit register select
// R17 - bits 19:18 read as zero
`timescale 1ns/100ps
`default_nettype none
`include "dcs_defs.svh"
module dcs_top (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire dcs_pkg::dcs_req_t port_req,
    input wire dcs_pkg::dcs_req_t cpu_req,
    input wire logic cpu_supervisor,
    input wire logic resume_cmd,
    input wire dcs_pkg::dcs_cause_t cause,
    input wire logic bp_level1_enable,
    input wire logic bp_level2_enable,
    input wire logic bp_level1_hit,
    input wire logic bp_level2_hit,
    input wire dcs_pkg::dcs_trace_t trace_in,
    input wire logic trace_clock_in,
    input wire logic trace_clock_off,
    output logic [31:0] port_rdata,
    output logic port_rvalid,
    output logic cpu_write_blocked,
    output logic trace_output_disable,
    output logic processor_write_lock,
    output dcs_pkg::dcs_trace_t trace_out,
    output logic trace_clock
);
    import dcs_pkg::*;

    // ****************************************
    // access decode
    // ****************************************
    logic port_rd_cfg, port_wr_cfg, cpu_wr_cfg, trigdef_wr, cpu_ok;
    logic [31:0] read_word;
    // decode one select against a register number
    function automatic logic hits(input logic [4:0] sel, input logic [4:0] reg_no);
        return sel == reg_no;
    endfunction
    // processor writes need supervisor mode and no lock
    assign cpu_ok = cpu_req.wr & cpu_supervisor & ~processor_write_lock; // [R12]
    assign cpu_write_blocked = cpu_req.wr & cpu_supervisor & processor_write_lock; // [R12]
    assign port_rd_cfg = port_req.rd & hits(port_req.sel, `DCS_SEL_CFG); // [R15] [R16] [R14]
    assign port_wr_cfg = port_req.wr & hits(port_req.sel, `DCS_SEL_CFG); // [R15]
    assign cpu_wr_cfg = cpu_ok & hits(cpu_req.sel, `DCS_SEL_CFG); // [R15]
    assign trigdef_wr = (port_req.wr & hits(port_req.sel, `DCS_SEL_TRIGDEF))
        | (cpu_ok & hits(cpu_req.sel, `DCS_SEL_TRIGDEF));

    // ****************************************
    // breakpoint sequencing state
    // ****************************************
    dcs_bstate_t bstate, next_bstate;
    logic [3:0] state_code;
    // state never takes write data; only hits, enables and clears move it
    always_comb begin
        next_bstate = bstate;
        case (bstate)
            DCS_IDLE: begin
                if (bp_level1_enable) begin
                    next_bstate = DCS_WAIT1;
                end
            end
            DCS_WAIT1: begin
                if (bp_level1_hit) begin
                    next_bstate = bp_level2_enable ? DCS_WAIT2 : DCS_HIT1; // [R2]
                end
            end
            DCS_WAIT2: begin
                if (bp_level2_hit) begin
                    next_bstate = DCS_HIT2; // [R2]
                end
            end
            DCS_HIT1: begin
                if (port_rd_cfg) begin
                    next_bstate = DCS_IDLE; // [R3]
                end
            end
            DCS_HIT2: begin
                if (port_rd_cfg) begin
                    next_bstate = DCS_IDLE; // [R3]
                end
            end
            default: begin
                next_bstate = DCS_IDLE;
            end
        endcase
        if (trigdef_wr) begin
            next_bstate = DCS_IDLE; // [R3]
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bstate <= DCS_IDLE;
        end else begin
            bstate <= next_bstate;
        end
    end
    // encoding seen on the debug port
    always_comb begin
        case (bstate)
            DCS_WAIT1: state_code = `DCS_BS_WAIT1; // [R1]
            DCS_HIT1: state_code = `DCS_BS_HIT1; // [R2]
            DCS_WAIT2: state_code = `DCS_BS_WAIT2; // [R1]
            DCS_HIT2: state_code = `DCS_BS_HIT2; // [R2]
            default: state_code = `DCS_BS_IDLE; // [R1]
        endcase
    end

    // ****************************************
    // debug-entry cause flags
    // ****************************************
    logic fault_flag, trig_flag, hlt, xbrk, go_clear;
    assign go_clear = port_rd_cfg | resume_cmd;
    dcs_flag u_fault (.core_clk(core_clk), .reset_n(reset_n), .set(cause.double_fault),
        .clear(port_rd_cfg), .flag(fault_flag)); // [R5]
    dcs_flag u_trig (.core_clk(core_clk), .reset_n(reset_n), .set(cause.hw_trigger),
        .clear(go_clear), .flag(trig_flag)); // [R6]
    dcs_flag u_hlt (.core_clk(core_clk), .reset_n(reset_n), .set(cause.halt_instr),
        .clear(go_clear), .flag(hlt)); // [R7]
    dcs_flag u_xbrk (.core_clk(core_clk), .reset_n(reset_n), .set(cause.external_break),
        .clear(go_clear), .flag(xbrk)); // [R8]

    // ****************************************
    // writable control bits
    // ****************************************
    logic next_trace_off, next_lock;
    // debug port wins over a same-cycle processor write
    always_comb begin
        next_trace_off = trace_output_disable;
        next_lock = processor_write_lock;
        if (port_wr_cfg) begin
            next_trace_off = port_req.data[`DCS_TRACE_OFF_BIT];
            next_lock = port_req.data[`DCS_LOCK_BIT]; // [R13]
        end else if (cpu_wr_cfg) begin
            next_trace_off = cpu_req.data[`DCS_TRACE_OFF_BIT]; // [R14]
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            trace_output_disable <= `DCS_TRACE_OFF_RESET;
            processor_write_lock <= `DCS_LOCK_RESET;
        end else begin
            trace_output_disable <= next_trace_off;
            processor_write_lock <= next_lock;
        end
    end

    // ****************************************
    // debug-port read data
    // ****************************************
    // processor side has no read path at all
    always_comb begin
        read_word = '0; // [R17]
        read_word[`DCS_STATE_MSB:`DCS_STATE_LSB] = state_code; // [R4]
        read_word[`DCS_FAULT_BIT] = fault_flag;
        read_word[`DCS_TRIG_BIT] = trig_flag;
        read_word[`DCS_HALT_BIT] = hlt;
        read_word[`DCS_XBRK_BIT] = xbrk;
        read_word[`DCS_REV_MSB:`DCS_REV_LSB] = `DCS_REV_CODE; // [R9]
        read_word[`DCS_TRACE_OFF_BIT] = trace_output_disable;
        read_word[`DCS_LOCK_BIT] = processor_write_lock;
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            port_rdata <= '0;
            port_rvalid <= 1'b0;
        end else begin
            port_rdata <= port_rd_cfg ? read_word : '0; // [R14]
            port_rvalid <= port_rd_cfg;
        end
    end

    // ****************************************
    // trace outputs
    // ****************************************
    dcs_trace_gate u_gate (.core_clk(core_clk), .reset_n(reset_n),
        .disable_trace(trace_output_disable), .trace_in(trace_in), .trace_out(trace_out)); // [R10]
    // clock gate ignores the trace disable on purpose
    assign trace_clock = trace_clock_in & ~trace_clock_off; // [R11]

    // ****************************************
    // checks
    // ****************************************
    sequence s_final_read;
        port_rd_cfg && (bstate == DCS_HIT2 || bstate == DCS_HIT1);
    endsequence
    // a level-one hit either ends a one-level setup or arms level two
    sequence s_level1_only_hit;
        bstate == DCS_WAIT1 && bp_level1_hit && !bp_level2_enable && !trigdef_wr;
    endsequence
    sequence s_level1_chain_hit;
        bstate == DCS_WAIT1 && bp_level1_hit && bp_level2_enable && !trigdef_wr;
    endsequence
    a_state_read_clear: assert property (@(posedge core_clk) disable iff (!reset_n) // [R3]
        s_final_read ##1 1 |-> bstate == DCS_IDLE) else $error("state not cleared by read");
    a_state_tdef_clear: assert property (@(posedge core_clk) disable iff (!reset_n) // [R3]
        trigdef_wr |=> state_code == 4'h0) else $error("state not cleared by trigger write");
    a_state_hit2: assert property (@(posedge core_clk) disable iff (!reset_n) // [R2]
        bstate == DCS_WAIT2 && bp_level2_hit && !trigdef_wr |=> state_code == 4'h6)
        else $error("level two hit not shown");
    a_state_wait1: assert property (@(posedge core_clk) disable iff (!reset_n) // [R1]
        bstate == DCS_WAIT1 |-> state_code == 4'h1) else $error("wait one code wrong");
    a_state_hit1: assert property (@(posedge core_clk) disable iff (!reset_n) // [R2]
        s_level1_only_hit |=> state_code == 4'h2) else $error("level one hit not shown");
    a_state_wait2: assert property (@(posedge core_clk) disable iff (!reset_n) // [R1]
        s_level1_chain_hit |=> state_code == 4'h5) else $error("wait two code wrong");
    a_state_enable: assert property (@(posedge core_clk) disable iff (!reset_n) // [R1]
        bstate == DCS_IDLE && bp_level1_enable && !trigdef_wr |=> state_code == 4'h1)
        else $error("enabled level one not awaited");
    // write data must never reach the state, whatever bits 31:28 carry
    a_state_readonly: assert property (@(posedge core_clk) disable iff (!reset_n) // [R4]
        port_wr_cfg && !port_req.rd && !bp_level1_enable && !bp_level1_hit && !bp_level2_hit && !trigdef_wr
        |=> $stable(bstate)) else $error("state moved by a write");

    // ****************************************
    // flag checks
    // ****************************************
    // a cause pulse sets its flag on the next edge, even during a read
    a_fault_set: assert property (@(posedge core_clk) disable iff (!reset_n) // [R5]
        cause.double_fault |=> fault_flag) else $error("double fault not flagged");
    a_flag_clear: assert property (@(posedge core_clk) disable iff (!reset_n) // [R6]
        resume_cmd && !cause.hw_trigger |=> !trig_flag) else $error("trigger flag not cleared");
    a_halt_set: assert property (@(posedge core_clk) disable iff (!reset_n) // [R7]
        cause.halt_instr |=> hlt) else $error("halt flag not set");
    a_trig_set: assert property (@(posedge core_clk) disable iff (!reset_n) // [R6]
        cause.hw_trigger |=> trig_flag) else $error("trigger flag not set");
    a_break_set: assert property (@(posedge core_clk) disable iff (!reset_n) // [R8]
        cause.external_break |=> xbrk) else $error("break flag not set");
    a_xbrk_read: assert property (@(posedge core_clk) disable iff (!reset_n) // [R8]
        port_rd_cfg && !cause.external_break |=> !xbrk) else $error("break flag not cleared");
    a_fault_read: assert property (@(posedge core_clk) disable iff (!reset_n) // [R5]
        port_rd_cfg && !cause.double_fault |=> !fault_flag) else $error("fault flag not cleared");
    a_halt_clear: assert property (@(posedge core_clk) disable iff (!reset_n) // [R7]
        port_rd_cfg && !cause.halt_instr |=> !hlt) else $error("halt flag not cleared");
    // resume leaves the fault flag alone; only a port read drops it
    a_fault_resume: assert property (@(posedge core_clk) disable iff (!reset_n) // [R5]
        resume_cmd && fault_flag && !port_rd_cfg |=> fault_flag) else $error("fault flag lost on resume");

    // ****************************************
    // register bit checks
    // ****************************************
    a_rev_code: assert property (@(posedge core_clk) disable iff (!reset_n) // [R9]
        port_rd_cfg |=> port_rdata[`DCS_REV_MSB:`DCS_REV_LSB] == `DCS_REV_CODE && port_rdata[19:18] == 2'b00)
        else $error("revision or reserved bits wrong");
    // read word shows the control bits as they stood at the read
    a_read_bits: assert property (@(posedge core_clk) disable iff (!reset_n) // [R14]
        port_rd_cfg |=> port_rvalid && port_rdata[`DCS_TRACE_OFF_BIT] == $past(trace_output_disable)
        && port_rdata[`DCS_LOCK_BIT] == $past(processor_write_lock)) else $error("control bits misread");
    // the processor has no read path, so nothing answers without a port read
    a_no_read: assert property (@(posedge core_clk) disable iff (!reset_n) // [R14]
        !port_rd_cfg |=> !port_rvalid && port_rdata == 32'h0) else $error("data without a port read");
    a_port_write: assert property (@(posedge core_clk) disable iff (!reset_n) // [R13]
        port_wr_cfg |=> trace_output_disable == $past(port_req.data[`DCS_TRACE_OFF_BIT])
        && processor_write_lock == $past(port_req.data[`DCS_LOCK_BIT])) else $error("port write not taken");
    a_lock_hold: assert property (@(posedge core_clk) disable iff (!reset_n) // [R13]
        !port_wr_cfg |=> processor_write_lock == $past(processor_write_lock))
        else $error("lock changed without debug port");
    a_cpu_blocked: assert property (@(posedge core_clk) disable iff (!reset_n) // [R12]
        processor_write_lock && !port_wr_cfg |=> $stable(trace_output_disable))
        else $error("processor write passed lock");
    a_cpu_write: assert property (@(posedge core_clk) disable iff (!reset_n) // [R14]
        cpu_wr_cfg && !port_wr_cfg |=> trace_output_disable == $past(cpu_req.data[`DCS_TRACE_OFF_BIT]))
        else $error("processor write not taken");
    // a locked processor cannot reach the trigger definition either
    a_blocked_tdef: assert property (@(posedge core_clk) disable iff (!reset_n) // [R12]
        processor_write_lock && !port_req.wr |-> !trigdef_wr) else $error("locked processor cleared state");

    // ****************************************
    // trace checks
    // ****************************************
    a_trace_quiet: assert property (@(posedge core_clk) disable iff (!reset_n) // [R10]
        trace_output_disable ##1 trace_output_disable |-> trace_out == '0)
        else $error("trace not quiet");
    // enabled trace is the raw trace one edge late
    a_trace_pass: assert property (@(posedge core_clk) disable iff (!reset_n) // [R10]
        !trace_output_disable |=> trace_out == $past(trace_in)) else $error("trace not passed");
    // clock path checked with the trace disable in either state
    a_clock_off: assert property (@(posedge core_clk) disable iff (!reset_n) // [R11]
        trace_clock_off |-> !trace_clock) else $error("trace clock not stopped");
    a_clock_on: assert property (@(posedge core_clk) disable iff (!reset_n) // [R11]
        !trace_clock_off |-> trace_clock == trace_clock_in) else $error("trace clock not passed");
endmodule
`default_nettype wire

// ==== src/dcs_defs.svh ====
// constants for the debug configuration/status register, upper half
// assumes: included by bare name from package and design files
`ifndef DCS_DEFS_SVH
`define DCS_DEFS_SVH
`define DCS_SEL_CFG 5'h00
`define DCS_SEL_TRIGDEF 5'h07
`define DCS_STATE_MSB 31
`define DCS_STATE_LSB 28
`define DCS_FAULT_BIT 27
`define DCS_TRIG_BIT 26
`define DCS_HALT_BIT 25
`define DCS_XBRK_BIT 24
`define DCS_REV_MSB 23
`define DCS_REV_LSB 20
`define DCS_TRACE_OFF_BIT 17
`define DCS_LOCK_BIT 16
`define DCS_BS_IDLE 4'h0
`define DCS_BS_WAIT1 4'h1
`define DCS_BS_HIT1 4'h2
`define DCS_BS_WAIT2 4'h5
`define DCS_BS_HIT2 4'h6
// revision code value is arbitrary
`define DCS_REV_CODE 4'h3
`define DCS_TRACE_OFF_RESET 1'b0
`define DCS_LOCK_RESET 1'b0
`define DCS_TRACE_IDLE 4'h0
`endif

// ==== src/dcs_pkg.sv ====
// types for the debug configuration/status register
// assumes: dcs_defs.svh on the include path
`include "dcs_defs.svh"
package dcs_pkg;
    // one register access from either requester
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] sel;
        logic [31:0] data;
    } dcs_req_t;
    // trace outputs
    typedef struct packed {
        logic [3:0] status;
        logic [3:0] data;
    } dcs_trace_t;
    // debug-entry causes, one-cycle pulses
    typedef struct packed {
        logic double_fault;
        logic hw_trigger;
        logic halt_instr;
        logic external_break;
    } dcs_cause_t;
    typedef enum logic [2:0] {
        DCS_IDLE, DCS_WAIT1, DCS_HIT1, DCS_WAIT2, DCS_HIT2
    } dcs_bstate_t;
endpackage

// ==== src/dcs_flag.sv ====
// one sticky debug-entry flag
// assumes: core_clk domain, set wins over clear
`timescale 1ns/100ps
`default_nettype none
module dcs_flag (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic set,
    input wire logic clear,
    output logic flag
);
    logic next_flag;
    // set wins so a cause seen during a read is kept
    always_comb begin
        next_flag = set | (flag & ~clear);
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end
endmodule
`default_nettype wire

// ==== src/dcs_trace_gate.sv ====
// trace output gating
// assumes: trace source on core_clk; trace clock handled elsewhere
`timescale 1ns/100ps
`default_nettype none
module dcs_trace_gate (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic disable_trace,
    input wire dcs_pkg::dcs_trace_t trace_in,
    output dcs_pkg::dcs_trace_t trace_out
);
    import dcs_pkg::*;
    dcs_trace_t next_trace;
    // quiescent value while disabled
    always_comb begin
        if (disable_trace) begin
            next_trace.status = `DCS_TRACE_IDLE;
            next_trace.data = `DCS_TRACE_IDLE;
        end else begin
            next_trace = trace_in;
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            trace_out <= '0;
        end else begin
            trace_out <= next_trace;
        end
    end
endmodule
`default_nettype wire

// ==== tb/dcs_host_model.sv ====
// partner model: external development system on the debug serial port
// assumes: core_clk from the bench; requests change 1 ns after a rising edge
`timescale 1ns/100ps
`default_nettype none
module dcs_host_model (
    input wire logic core_clk,
    input wire logic [31:0] port_rdata,
    input wire logic port_rvalid,
    output var dcs_pkg::dcs_req_t port_req
);
    import dcs_pkg::*;
    // ************************************************
    // one register access, held over one taking edge
    // ************************************************
    initial port_req = '0;
    // released lines show the inverse pattern, so a stale value never passes for a live one
    task automatic access(input logic wr, input logic [4:0] sel, input logic [31:0] d,
                          output logic [31:0] q, output logic ok);
        @(posedge core_clk);
        #1;
        port_req = '{wr: wr, rd: ~wr, sel: sel, data: d & 32'hfff3ffff};
        @(posedge core_clk);
        #1;
        q = port_rdata;
        ok = port_rvalid;
        port_req = '{wr: 1'b0, rd: 1'b0, sel: ~sel, data: ~port_req.data};
    endtask
endmodule
`default_nettype wire

// ==== tb/tb_debug_config_status_register.sv ====
// bench for the debug configuration/status register
// assumes: dcs_pkg and dcs_defs.svh compiled first; host model drives the debug port
`timescale 1ns/100ps
`default_nettype none
`include "dcs_defs.svh"
module tb_debug_config_status_register;
    import dcs_pkg::*;
    localparam logic [31:0] rev_word = {8'h00, `DCS_REV_CODE, 20'h00000};
    logic core_clk, reset_n, cpu_supervisor, resume_cmd, bp_level1_enable, bp_level2_enable;
    logic bp_level1_hit, bp_level2_hit, trace_clock_in, trace_clock_off, trace_clock, ok;
    logic port_rvalid, cpu_write_blocked, trace_output_disable, processor_write_lock;
    logic [31:0] port_rdata, q;
    dcs_req_t port_req, cpu_req;
    dcs_cause_t cause;
    dcs_trace_t trace_in, trace_out;
    int bad_count = 0;
    int n_tests = 0;
    dcs_top u_dcs_top (.core_clk(core_clk), .reset_n(reset_n), .port_req(port_req), .cpu_req(cpu_req),
        .cpu_supervisor(cpu_supervisor), .resume_cmd(resume_cmd), .cause(cause),
        .bp_level1_enable(bp_level1_enable), .bp_level2_enable(bp_level2_enable),
        .bp_level1_hit(bp_level1_hit), .bp_level2_hit(bp_level2_hit), .trace_in(trace_in),
        .trace_clock_in(trace_clock_in), .trace_clock_off(trace_clock_off), .port_rdata(port_rdata),
        .port_rvalid(port_rvalid), .cpu_write_blocked(cpu_write_blocked),
        .trace_output_disable(trace_output_disable), .processor_write_lock(processor_write_lock),
        .trace_out(trace_out), .trace_clock(trace_clock));
    dcs_host_model u_dcs_host_model (.core_clk(core_clk), .port_rdata(port_rdata),
        .port_rvalid(port_rvalid), .port_req(port_req));
    // ************************************************
    // helpers
    // ************************************************
    task automatic wrap_up();
        if (bad_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // debug-port read; only select 0x00 answers
    task automatic rd(input logic [4:0] sel, input logic [31:0] exp);
        u_dcs_host_model.access(1'b0, sel, 32'h0, q, ok);
        chk("read valid", {31'h0, sel == 5'h00}, {31'h0, ok});
        if (sel == 5'h00) begin
            chk("read word", exp, q);
        end
    endtask
    task automatic wr(input logic [4:0] sel, input logic [31:0] d);
        u_dcs_host_model.access(1'b1, sel, d, q, ok);
    endtask
    // processor write; the blocked flag stands only in the request cycle
    task automatic cpu_wr(input logic sup, input logic [4:0] sel, input logic [31:0] d, input logic blk);
        @(posedge core_clk);
        #1;
        cpu_req = '{wr: 1'b1, rd: 1'b0, sel: sel, data: d};
        cpu_supervisor = sup;
        #1;
        chk("write blocked", {31'h0, blk}, {31'h0, cpu_write_blocked});
        @(posedge core_clk);
        #1;
        cpu_req = '0;
    endtask
    // one-cycle pulses of causes, level hits and resume
    task automatic fire(input logic [3:0] c, input logic h1, input logic h2, input logic go);
        @(posedge core_clk);
        #1;
        cause = c;
        bp_level1_hit = h1;
        bp_level2_hit = h2;
        resume_cmd = go;
        @(posedge core_clk);
        #1;
        cause = '0;
        bp_level1_hit = 1'b0;
        bp_level2_hit = 1'b0;
        resume_cmd = 1'b0;
    endtask
    // ************************************************
    // clock, watchdog, tests
    // ************************************************
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // run needs under 100 cycles; 2000 means a hang
    initial begin
        #(2000 * 100);
        bad_count++;
        wrap_up();
    end
    initial begin
        reset_n = 1'b0;
        cpu_req = '0;
        cpu_supervisor = 1'b0;
        {resume_cmd, bp_level1_enable, bp_level2_enable, bp_level1_hit, bp_level2_hit} = 5'h00;
        cause = '0;
        trace_in = 8'ha5;
        trace_clock_in = 1'b0;
        trace_clock_off = 1'b0;
        repeat (20) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        rd(5'h00, rev_word);
        rd(5'h01, 32'h0);
        fire(4'hf, 1'b0, 1'b0, 1'b0);
        rd(5'h00, rev_word | 32'h0f000000);
        rd(5'h00, rev_word);
        fire(4'hf, 1'b0, 1'b0, 1'b0);
        fire(4'h0, 1'b0, 1'b0, 1'b1);
        rd(5'h00, rev_word | 32'h08000000);
        wr(5'h00, 32'hf0030000);
        rd(5'h00, rev_word | 32'h00030000);
        chk("trace out", 32'h0, {24'h0, trace_out});
        trace_clock_in = 1'b1;
        #1;
        chk("trace clock", 32'h1, {31'h0, trace_clock});
        trace_clock_off = 1'b1;
        #1;
        chk("trace clock", 32'h0, {31'h0, trace_clock});
        cpu_wr(1'b1, 5'h00, 32'h0, 1'b1);
        chk("disable bit", 32'h1, {31'h0, trace_output_disable});
        wr(5'h00, 32'h00020000);
        cpu_wr(1'b0, 5'h00, 32'h0, 1'b0);
        chk("disable bit", 32'h1, {31'h0, trace_output_disable});
        cpu_wr(1'b1, 5'h00, 32'h00010000, 1'b0);
        rd(5'h00, rev_word);
        chk("lock bit", 32'h0, {31'h0, processor_write_lock});
        chk("trace out", 32'ha5, {24'h0, trace_out});
        // two-level sequence, enables dropped before the final read
        {bp_level1_enable, bp_level2_enable} = 2'b11;
        rd(5'h00, rev_word | 32'h10000000);
        fire(4'h0, 1'b1, 1'b0, 1'b0);
        rd(5'h00, rev_word | 32'h50000000);
        fire(4'h0, 1'b0, 1'b1, 1'b0);
        {bp_level1_enable, bp_level2_enable} = 2'b00;
        rd(5'h00, rev_word | 32'h60000000);
        rd(5'h00, rev_word);
        // single level: read clears, then trigger-definition write clears
        bp_level1_enable = 1'b1;
        fire(4'h0, 1'b1, 1'b0, 1'b0);
        bp_level1_enable = 1'b0;
        rd(5'h00, rev_word | 32'h20000000);
        rd(5'h00, rev_word);
        bp_level1_enable = 1'b1;
        fire(4'h0, 1'b1, 1'b0, 1'b0);
        bp_level1_enable = 1'b0;
        cpu_wr(1'b1, 5'h07, 32'h0, 1'b0);
        rd(5'h00, rev_word);
        wrap_up();
    end
endmodule
`default_nettype wire
